// ==== fcg_defs.vh ====
`ifndef FCG_DEFS_VH
`define FCG_DEFS_VH

// Register indices on the 3-bit address port
`define FCG_ADDR_CTRL1      3'h0
`define FCG_ADDR_CTRL2      3'h1
`define FCG_ADDR_STATUS     3'h2
`define FCG_ADDR_FILTER     3'h3
`define FCG_ADDR_TRIM       3'h4
`define FCG_ADDR_DEBUG      3'h5

// clock_ctrl1 fields
`define FCG_C1_MODE_LSB     0
`define FCG_C1_MODE_MSB     1
`define FCG_C1_REF_SOURCE_SELECT_BIT     2
`define FCG_C1_HGO_BIT      3
`define FCG_C1_OSC_STOP_ENABLE_BIT  4
// clock_ctrl2 fields
`define FCG_C2_MULT_LSB     0
`define FCG_C2_MULT_MSB     2
`define FCG_C2_RDIV_LSB     3
`define FCG_C2_RDIV_MSB     5
`define FCG_C2_LOLRE_BIT    6
`define FCG_C2_LOCRE_BIT    7
// Status fields
`define FCG_ST_LOCS_BIT     0
`define FCG_ST_LOLS_BIT     1
`define FCG_ST_LOCK_BIT     2
`define FCG_ST_ERCS_BIT     3
`define FCG_ST_MODE_LSB     4
`define FCG_ST_MODE_MSB     6

// Mode select encodings
`define FCG_SEL_SELF        2'h0
`define FCG_SEL_LOOP_INT    2'h1
`define FCG_SEL_BYP_EXT     2'h2
`define FCG_SEL_LOOP_EXT    2'h3

// Reset values and filter word limits
`define FCG_FILT_RESET      16'h28f6
`define FCG_FILT_MIN        16'h28f6
`define FCG_FILT_MAX        16'hcccc
`define FCG_TRIM_RESET      8'h80

// Timing and counts
`define FCG_CLK_NS          10
`define FCG_LOSS_NS         40000
`define FCG_LOSS_CYC        (`FCG_LOSS_NS / `FCG_CLK_NS)
`define FCG_OSC_OUTPUT_PIN_EDGES      13'd4096
`define FCG_EXT_EDGES       13'd4
`define FCG_IRG_BASE        12'h11b
`define FCG_REF_WIN         3'h3
`define FCG_LOCK_TOL        13'd2
`define FCG_UNLOCK_TOL      13'd6
`define FCG_LOCK_SAMPLES    4'h3
`define FCG_KSHIFT          4

`endif

// ==== fcg_clock_gen.v ====
`include "fcg_defs.vh"

module fcg_clock_gen (
    input  wire        clk_in,            // 100 MHz system clock
    input  wire        rst_in,            // Chip reset, async, high
    input  wire        por_in,            // Power-on reset for trim, high
    input  wire [2:0]  addr_in,           // Register index
    input  wire [15:0] wdata_in,          // Write data
    input  wire        wr_in,             // Write strobe
    input  wire        rd_in,             // Read strobe
    input  wire        stop_in,           // Processor in stop, level
    input  wire        ref_clk_in,        // Reference input pin level
    output reg  [15:0] rdata_out,         // Read data, cycle after read
    output reg         sys_clk_out,       // System clock feed
    output reg         mult_clk_out,      // Multiplied clock
    output reg         ref_pin_used_out,  // Reference pin claimed
    output reg         ref_pin_osc_out,   // Pin used as oscillator input
    output reg         osc_pin_out,       // Oscillator output pin data
    output reg         osc_pin_oe_n_out,  // Oscillator pin enable, low on
    output reg         high_gain_out,     // Oscillator high amplitude
    output reg         reset_req_out,     // Loss reset request pulse
    output reg         irq_out            // Loss interrupt level
);

    // Clock generator states
    localparam ST_OFF  = 3'h0;
    localparam ST_SCM  = 3'h1;
    localparam ST_FEI  = 3'h2;
    localparam ST_FBE  = 3'h3;
    localparam ST_FEE  = 3'h4;
    localparam ST_HOLD = 3'h5;
    // Output source selection
    localparam SRC_NONE = 2'h0;
    localparam SRC_DCO  = 2'h1;
    localparam SRC_EXT  = 2'h2;
    localparam [31:0] LOSS_W   = `FCG_LOSS_CYC;
    localparam [15:0] LOSS_CYC = LOSS_W[15:0];

    // Loop target count per comparison: 8 x (4 + 2 x mult)
    function [11:0] fcg_target;
        input [2:0] m;
        begin
            fcg_target = 12'h020 + {5'h00, m, 4'h0};
        end
    endfunction

    // Magnitude of a signed count error
    function [12:0] fcg_abs;
        input [12:0] e;
        begin
            fcg_abs = e[12] ? (~e + 13'h0001) : e;
        end
    endfunction

    // Apply a correction and keep the oscillator word in range
    function [15:0] fcg_clamp;
        input [15:0] f;
        input [12:0] e;
        reg   [19:0] s;
        begin
            s = {4'h0, f} - ({{7{e[12]}}, e} << `FCG_KSHIFT);
            if (s[19] || s < {4'h0, `FCG_FILT_MIN})
                fcg_clamp = `FCG_FILT_MIN;
            else if (s > {4'h0, `FCG_FILT_MAX})
                fcg_clamp = `FCG_FILT_MAX;
            else
                fcg_clamp = s[15:0];
        end
    endfunction

    reg  [1:0]  mode_sel_r;
    reg         ref_source_select_r;
    reg         hgo_r;
    reg         osc_stop_enable_r;
    reg  [2:0]  mult_r;
    reg  [2:0]  rdiv_r;
    reg         lolre_r;
    reg         locre_r;
    reg         dbg_en_r;
    reg  [15:0] filt_r;
    reg  [7:0]  trim_r;
    reg         claimed_r;
    reg         pin_ext_r;
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg         stop_exit_r;
    reg         ext_valid_r;
    reg  [12:0] ext_cnt_r;
    reg  [15:0] loss_cnt_r;
    reg         ref_in_r;
    reg  [15:0] acc_r;
    reg  [11:0] irg_cnt_r;
    reg  [2:0]  win_ref_r;
    reg  [11:0] win_cnt_r;
    reg         lock_r;
    reg  [3:0]  lock_run_r;
    reg  [12:0] avg_acc_r;
    reg  [1:0]  avg_n_r;
    reg         lols_r;
    reg         locs_r;
    reg         ever_lock_r;
    reg  [1:0]  sel_src_r;
    reg  [8:0]  sel_lim_r;
    reg  [8:0]  div_cnt_r;
    reg  [1:0]  want_src;
    reg  [8:0]  want_lim;

    wire        full_off  = (state_r == ST_OFF) && !osc_stop_enable_r;
    wire        stop_eff  = stop_in && !dbg_en_r;
    // Waking covers the exit edge itself, so no self-clocked cycle slips in
    wire        waking    = stop_exit_r || (state_r == ST_OFF);
    wire        ext_rise  = pin_ext_r && ref_clk_in && !ref_in_r;
    wire        ext_any   = pin_ext_r && (ref_clk_in ^ ref_in_r);
    wire [16:0] acc_sum   = {1'b0, acc_r} + {1'b0, filt_r};
    wire        dco_tick  = !full_off && acc_sum[16];
    wire        irg_tick  = !full_off && (irg_cnt_r == 12'h000);
    wire        loop_on   = (state_r == ST_FEI) || (state_r == ST_FEE);
    wire        ref_tick  = (state_r == ST_FEE) ? ext_rise : irg_tick;
    wire        win_end   = loop_on && ref_tick &&
                            (win_ref_r == `FCG_REF_WIN);
    wire [12:0] err       = {1'b0, win_cnt_r} - {1'b0, fcg_target(mult_r)};
    wire [12:0] err_mag   = fcg_abs(err);
    wire [12:0] avg_sum   = avg_acc_r + err;
    wire        loss_now  = ext_valid_r && !ext_any &&
                            (loss_cnt_r == LOSS_CYC - 16'h0001);
    wire        locs_set  = loss_now && mode_sel_r[1];
    wire        lols_set  = win_end && lock_r && (err_mag > `FCG_UNLOCK_TOL);
    wire        wr_st     = wr_in && (addr_in == `FCG_ADDR_STATUS);
    wire        src_tick  = (sel_src_r == SRC_DCO) ? dco_tick :
                            (sel_src_r == SRC_EXT) ? ext_any : 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Register writes; control resets to defaults on chip reset
    // defaults restored
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_sel_r <= `FCG_SEL_SELF;
            ref_source_select_r     <= 1'b0;
            hgo_r      <= 1'b0;
            osc_stop_enable_r  <= 1'b0;
            mult_r     <= 3'h0;
            rdiv_r     <= 3'h1;
            lolre_r    <= 1'b0;
            locre_r    <= 1'b0;
            dbg_en_r   <= 1'b0;
            claimed_r  <= 1'b0;
            pin_ext_r  <= 1'b0;
        end else if (wr_in) begin
            if (addr_in == `FCG_ADDR_CTRL1) begin
                mode_sel_r <= wdata_in[`FCG_C1_MODE_MSB:`FCG_C1_MODE_LSB];
                ref_source_select_r     <= wdata_in[`FCG_C1_REF_SOURCE_SELECT_BIT];
                hgo_r      <= wdata_in[`FCG_C1_HGO_BIT];
                osc_stop_enable_r  <= wdata_in[`FCG_C1_OSC_STOP_ENABLE_BIT];
                claimed_r  <= 1'b1;
                if (!claimed_r)
                    pin_ext_r <= wdata_in[`FCG_C1_MODE_MSB];
            end else if (addr_in == `FCG_ADDR_CTRL2) begin
                mult_r  <= wdata_in[`FCG_C2_MULT_MSB:`FCG_C2_MULT_LSB];
                rdiv_r  <= wdata_in[`FCG_C2_RDIV_MSB:`FCG_C2_RDIV_LSB];
                lolre_r <= wdata_in[`FCG_C2_LOLRE_BIT];
                locre_r <= wdata_in[`FCG_C2_LOCRE_BIT];
            end else if (addr_in == `FCG_ADDR_DEBUG) begin
                dbg_en_r <= wdata_in[0];
            end
        end
    end

    // Trim survives chip reset, only power-on resets it to 8'h80
    // trim kept
    always @(posedge clk_in or posedge por_in) begin
        if (por_in)
            trim_r <= `FCG_TRIM_RESET;
        else if (wr_in && addr_in == `FCG_ADDR_TRIM)
            trim_r <= wdata_in[7:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Mode selection; dead external sources fall back to self-clocked, except after a stop exit, where bypass holds and the loop runs internal
    always @* begin
        state_nxt = ST_SCM;
        if (stop_eff) begin
            state_nxt = ST_OFF;
        end else begin
            case (mode_sel_r)
                `FCG_SEL_SELF: state_nxt = ST_SCM;
                `FCG_SEL_LOOP_INT: state_nxt = ST_FEI;
                `FCG_SEL_BYP_EXT: begin
                    if (ext_valid_r)
                        state_nxt = ST_FBE;
                    else if (waking)
                        state_nxt = ST_HOLD;
                    else
                        state_nxt = ST_SCM;
                end
                default: begin
                    if (ext_valid_r)
                        state_nxt = ST_FEE;
                    else if (waking)
                        state_nxt = ST_FEI;
                    else
                        state_nxt = ST_SCM;
                end
            endcase
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r     <= ST_SCM;
            stop_exit_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_OFF && !stop_eff)
                stop_exit_r <= 1'b1;
            else if (ext_valid_r || !mode_sel_r[1])
                stop_exit_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // External reference qualification and loss detection
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_in_r    <= 1'b0;
            ext_valid_r <= 1'b0;
            ext_cnt_r   <= 13'h0000;
            loss_cnt_r  <= 16'h0000;
        end else begin
            ref_in_r <= ref_clk_in;
            // Full off stops the oscillator, so it must requalify
            if (!pin_ext_r || full_off) begin
                ext_valid_r <= 1'b0;
                ext_cnt_r   <= 13'h0000;
                loss_cnt_r  <= 16'h0000;
            end else if (ext_any) begin
                loss_cnt_r <= 16'h0000;
                if (ext_rise && !ext_valid_r) begin
                    ext_cnt_r <= ext_cnt_r + 13'h0001;
                    if (ext_cnt_r + 13'h0001 >=
                        (ref_source_select_r ? `FCG_OSC_OUTPUT_PIN_EDGES : `FCG_EXT_EDGES))
                        ext_valid_r <= 1'b1;
                end
            end else if (loss_now) begin
                ext_valid_r <= 1'b0;
                ext_cnt_r   <= 13'h0000;
                loss_cnt_r  <= 16'h0000;
            end else if (ext_valid_r) begin
                loss_cnt_r <= loss_cnt_r + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator model: phase accumulator, carry marks each edge.
    // Internal reference is a trimmed divider of the system clock.
    // free-running oscillator
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_r        <= 16'h0000;
            irg_cnt_r    <= 12'h000;
            mult_clk_out <= 1'b0;
        end else if (!full_off) begin
            acc_r <= acc_sum[15:0];
            if (dco_tick)
                mult_clk_out <= !mult_clk_out;
            if (irg_tick)
                irg_cnt_r <= `FCG_IRG_BASE + {4'h0, trim_r} - 12'h080;
            else
                irg_cnt_r <= irg_cnt_r - 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frequency loop: count oscillator edges over a reference window,
    // correct the filter word, and track lock.
    // internal loop
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            filt_r      <= `FCG_FILT_RESET;
            win_ref_r   <= 3'h0;
            win_cnt_r   <= 12'h000;
            lock_r      <= 1'b0;
            lock_run_r  <= 4'h0;
            avg_acc_r   <= 13'h0000;
            avg_n_r     <= 2'h0;
            ever_lock_r <= 1'b0;
        end else if (!loop_on) begin
            win_ref_r  <= 3'h0;
            win_cnt_r  <= 12'h000;
            lock_r     <= 1'b0;
            lock_run_r <= 4'h0;
            avg_n_r    <= 2'h0;
            avg_acc_r  <= 13'h0000;
            if (state_r != ST_OFF)
                ever_lock_r <= 1'b0;
            // Filter word is writable only in the self-clocked state
            if (wr_in && addr_in == `FCG_ADDR_FILTER && state_r == ST_SCM)
                filt_r <= fcg_clamp(wdata_in, 13'h0000);
        end else begin
            if (dco_tick && win_cnt_r != 12'hfff)
                win_cnt_r <= win_cnt_r + 12'h001;
            if (ref_tick)
                win_ref_r <= win_ref_r + 3'h1;
            if (win_end) begin
                win_ref_r <= 3'h0;
                win_cnt_r <= {11'h000, dco_tick};
                if (!lock_r) begin
                    filt_r <= fcg_clamp(filt_r, err);
                end else begin
                    // Locked: average four errors to steady the word
                    avg_n_r   <= avg_n_r + 2'h1;
                    avg_acc_r <= avg_sum;
                    if (avg_n_r == 2'h3) begin
                        filt_r <= fcg_clamp(filt_r,
                                   {{2{avg_sum[12]}}, avg_sum[12:2]});
                        avg_acc_r <= 13'h0000;
                    end
                end
                if (err_mag <= `FCG_LOCK_TOL) begin
                    if (lock_run_r == `FCG_LOCK_SAMPLES) begin
                        lock_r <= 1'b1;
                        if (state_r == ST_FEE)
                            ever_lock_r <= 1'b1;
                    end else begin
                        lock_run_r <= lock_run_r + 4'h1;
                    end
                end else begin
                    lock_run_r <= 4'h0;
                end
                if (lols_set) begin
                    lock_r  <= 1'b0;
                    avg_n_r <= 2'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky loss flags; a new event beats a same-cycle clear
    // loss status
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lols_r        <= 1'b0;
            locs_r        <= 1'b0;
            reset_req_out <= 1'b0;
            irq_out       <= 1'b0;
        end else begin
            lols_r <= lols_set ||
                      (lols_r && !(wr_st && wdata_in[`FCG_ST_LOLS_BIT]));
            locs_r <= locs_set ||
                      (locs_r && !(wr_st && wdata_in[`FCG_ST_LOCS_BIT]));
            reset_req_out <= (lols_set && lolre_r) || (locs_set && locre_r);
            irq_out <= (lols_r && !lolre_r) || (locs_r && !locre_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output source and divide limit wanted for the present state
    always @* begin
        want_src = SRC_DCO;
        want_lim = 9'h001 << rdiv_r;
        if (state_r == ST_OFF || state_r == ST_HOLD)
            want_src = SRC_NONE;
        else if (state_r == ST_FBE)
            want_src = SRC_EXT;
        if (state_r == ST_FEE && !ever_lock_r)
            want_lim = want_lim << 1;
    end

    // Divider toggles once per limit ticks. Selection changes only while
    // the output is low and restart the count, so a phase only grows.
    // Limitation: a source that dies while high parks the output high.
    // glitch-free switch
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_src_r   <= SRC_DCO;
            sel_lim_r   <= 9'h002;
            div_cnt_r   <= 9'h000;
            sys_clk_out <= 1'b0;
        end else if (!sys_clk_out &&
                     (sel_src_r != want_src || sel_lim_r != want_lim)) begin
            sel_src_r <= want_src;
            sel_lim_r <= want_lim;
            div_cnt_r <= 9'h000;
        end else if (src_tick) begin
            if (div_cnt_r + 9'h001 >= sel_lim_r) begin
                div_cnt_r   <= 9'h000;
                sys_clk_out <= !sys_clk_out;
            end else begin
                div_cnt_r <= div_cnt_r + 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin ownership and oscillator drive
    // oscillator pin claimed
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_pin_used_out <= 1'b0;
            ref_pin_osc_out  <= 1'b0;
            osc_pin_out      <= 1'b0;
            osc_pin_oe_n_out <= 1'b1;
            high_gain_out    <= 1'b0;
        end else begin
            ref_pin_used_out <= pin_ext_r;
            ref_pin_osc_out  <= pin_ext_r && ref_source_select_r;
            osc_pin_oe_n_out <= !pin_ext_r;
            osc_pin_out      <= pin_ext_r && !full_off && !ref_clk_in;
            high_gain_out    <= pin_ext_r && ref_source_select_r && hgo_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port; unmapped indices read zero
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            if (addr_in == `FCG_ADDR_CTRL1)
                rdata_out <= {11'h000, osc_stop_enable_r, hgo_r, ref_source_select_r, mode_sel_r};
            else if (addr_in == `FCG_ADDR_CTRL2)
                rdata_out <= {8'h00, locre_r, lolre_r, rdiv_r, mult_r};
            else if (addr_in == `FCG_ADDR_STATUS)
                rdata_out <= {9'h000, state_r, ext_valid_r, lock_r,
                              lols_r, locs_r};
            else if (addr_in == `FCG_ADDR_FILTER)
                rdata_out <= filt_r;
            else if (addr_in == `FCG_ADDR_TRIM)
                rdata_out <= {8'h00, trim_r};
            else if (addr_in == `FCG_ADDR_DEBUG)
                rdata_out <= {15'h0000, dbg_en_r};
            else
                rdata_out <= 16'h0000;
        end else begin
            rdata_out <= 16'h0000;
        end
    end

endmodule

// ==== fcg_clock_gen_properties.sv ====
`include "fcg_defs.vh"
module fcg_clock_gen_properties (
    input wire logic        clk_in, rst_in, wr_in, rd_in, stop_in,
    input wire logic [2:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        sys_clk_out, ref_pin_used_out, ref_pin_osc_out,
    input wire logic        osc_pin_out, osc_pin_oe_n_out, high_gain_out,
    input wire logic        reset_req_out
);
    logic [1:0] cause_r;
    logic       dbg_r;
    wire        c1_wr = wr_in && addr_in == `FCG_ADDR_CTRL1;

    // Shadow of software writes; a pin claim may land a cycle late
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cause_r <= 2'h0;
            dbg_r   <= 1'b0;
        end else begin
            cause_r <= {cause_r[0], c1_wr && wdata_in[1]};
            if (wr_in && addr_in == `FCG_ADDR_DEBUG) dbg_r <= wdata_in[0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_in_stop; (stop_in && !dbg_r) [*3]; endsequence
    property p_stop; s_in_stop ##0 !sys_clk_out |=> !sys_clk_out; endproperty
    property p_claim; $rose(ref_pin_used_out) |-> |cause_r; endproperty
    property p_hold; ref_pin_used_out |=> ref_pin_used_out; endproperty
    property p_oe; osc_pin_oe_n_out == !ref_pin_used_out; endproperty
    property p_idle; !ref_pin_used_out |-> !osc_pin_out; endproperty
    property p_osc; ref_pin_osc_out |-> ref_pin_used_out; endproperty
    property p_gain; high_gain_out |-> ref_pin_osc_out; endproperty
    property p_pulse; reset_req_out |=> !reset_req_out; endproperty
    a_stop: assert property (p_stop) else $error("clock moved");
    a_claim: assert property (p_claim) else $error("late claim");
    a_hold: assert property (p_hold) else $error("claim lost");
    a_oe: assert property (p_oe) else $error("pin enable");
    a_idle: assert property (p_idle) else $error("pin driven");
    a_osc: assert property (p_osc) else $error("osc input");
    a_gain: assert property (p_gain) else $error("gain");
    a_pulse: assert property (p_pulse) else $error("long pulse");
endmodule

bind fcg_clock_gen fcg_clock_gen_properties u_props (.clk_in, .rst_in,
    .wr_in, .rd_in, .stop_in, .addr_in, .wdata_in, .sys_clk_out,
    .ref_pin_used_out, .ref_pin_osc_out, .osc_pin_out, .osc_pin_oe_n_out,
    .high_gain_out, .reset_req_out);

// ==== fcg_ref_source.sv ====
module fcg_ref_source #(parameter int HALF_NS = 37) (
    input  wire logic run_in,  // Source powered and running
    output logic      ref_out  // Square wave to the reference pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Phase unrelated to the system clock; a dead source stands low
    initial begin
        ref_out = 1'b0;
        forever #(HALF_NS) ref_out = run_in ? ~ref_out : 1'b0;
    end
endmodule

// ==== fcg_clock_gen_tb.sv ====
`include "fcg_defs.vh"
module fcg_clock_gen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0, rst_in = 1'b1, por_in = 1'b1, rs = 1'b0;
    logic        wr_in = 1'b0, rd_in = 1'b0, stop_in = 1'b0, run = 1'b1;
    logic        sc, mc, rc, u, oi, oe, hg, rq, iq;
    logic [2:0]  addr_in = 3'h0;
    logic [15:0] wdata_in = 16'h0000, rdata_out, tv;
    logic [31:0] seed = 32'h90108511, e, q[$];
    int          bad_count = 0, n_tests = 0, ns, nm;

    always #5 clk_in = ~clk_in;
    fcg_ref_source src (.run_in(run), .ref_out(rc));
    fcg_clock_gen dut (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .stop_in(stop_in), .ref_clk_in(rc), .rdata_out(rdata_out),
        .sys_clk_out(sc), .mult_clk_out(mc), .ref_pin_used_out(u),
        .ref_pin_osc_out(oi), .osc_pin_out(), .osc_pin_oe_n_out(oe),
        .high_gain_out(hg), .reset_req_out(rq), .irq_out(iq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Expected value goes in as {mask, value}
    task automatic rreg(input logic [2:0] a, input logic [31:0] me);
        @(posedge clk_in);
        {addr_in, rd_in} <= {a, 1'b1};
        q.push_back(me);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask
    // Read data stand one cycle only, so look at them mid-cycle
    always @(posedge clk_in) rs <= rd_in;
    always @(negedge clk_in) begin
        if (rs === 1'b1) begin
            e = q.pop_front();
            check(rdata_out & e[31:16], e[15:0]);
        end
    end
    // Toggles of system and multiplied clocks over n cycles
    task automatic count(input int n);
        logic ps, pm;
        {ns, nm, ps, pm} = {32'd0, 32'd0, sc, mc};
        repeat (n) begin
            @(negedge clk_in);
            ns += int'(sc !== ps);
            nm += int'(mc !== pm);
            {ps, pm} = {sc, mc};
        end
        @(posedge clk_in);
    endtask
    task automatic div(input int r);
        count(1000);
        check({15'h0, nm >= r * (ns - 2) && nm <= r * (ns + 2)}, 16'h1);
    endtask
    // Pin outputs trail the control registers by one flop stage
    task automatic pins(input logic [15:0] x);
        @(posedge clk_in);
        @(negedge clk_in);
        check({11'h0, iq, u, oi, hg, oe}, x);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog: the tests need some 10600 cycles
    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_in);
        {rst_in, por_in} <= 2'b00;
        rreg(3'h0, 32'hffff_0000);
        rreg(3'h2, 32'h0070_0010);
        rreg(3'h7, 32'hffff_0000);
        seed = lfsr(seed);
        tv = {8'h00, seed[7:0]};
        wreg(3'h4, tv);
        rreg(3'h4, {16'h00ff, tv});
        pins(16'h0001);
        div(2);
        wreg(3'h1, 16'h0018);
        div(8);
        $display("test defaults done");
        // Crystal claim, then external clock with loss reset enabled
        wreg(3'h0, 16'h000f);
        pins(16'h000e);
        wreg(3'h0, 16'h0002);
        repeat (300) @(posedge clk_in);
        pins(16'h0008);
        rreg(3'h2, 32'h0078_0038);
        stop_in <= 1'b1;
        repeat (300) @(posedge clk_in);
        rreg(3'h2, 32'h0070_0000);
        count(500);
        check(ns[15:0] + nm[15:0], 16'h0000);
        stop_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rreg(3'h2, 32'h0070_0050);
        repeat (300) @(posedge clk_in);
        rreg(3'h2, 32'h0070_0030);
        rreg(3'h0, 32'h001f_0002);
        wreg(3'h1, 16'h0098);
        run <= 1'b0;
        ns = 0;
        repeat (6000) @(negedge clk_in) ns += int'(rq === 1'b1);
        check(ns[15:0], 16'h0001);
        rreg(3'h2, 32'h0079_0011);
        // Loss reset off: the held flag now shows as interrupt, then clears
        wreg(3'h1, 16'h0018);
        pins(16'h0018);
        wreg(3'h2, 16'h0001);
        pins(16'h0008);
        $display("test external done");
        // Reset mid-run: defaults back, trim kept, no claim
        {run, rst_in} <= 2'b11;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rreg(3'h0, 32'hffff_0000);
        rreg(3'h2, 32'h0070_0010);
        rreg(3'h4, {16'h00ff, tv});
        wreg(3'h0, 16'h0011);
        wreg(3'h0, 16'h0002);
        pins(16'h0001);
        wreg(3'h0, 16'h0011);
        wreg(3'h5, 16'h0001);
        stop_in <= 1'b1;
        repeat (50) @(posedge clk_in);
        rreg(3'h2, 32'h0070_0020);
        count(500);
        check({15'h0, ns > 0 && nm > 0}, 16'h0001);
        wreg(3'h5, 16'h0000);
        repeat (50) @(posedge clk_in);
        count(500);
        check({15'h0, ns == 0 && nm > 0}, 16'h0001);
        stop_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        rreg(3'h0, 32'h001f_0011);
        $display("test reset and stop done");
        report_and_stop();
    end
endmodule
